// >>> lsc_bbm_seq.sv
/*
 * Break-before-make sequencer for the three channel switches.
 * Assumes the select input is already synchronised to the clock.
 */
`timescale 1ns/1ps
module lsc_bbm_seq
    import lsc_pkg::*;
(
    // Clock and reset.
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    // Control.
    input  wire logic [1:0] i_sel,
    input  wire logic [7:0] i_bbm_code,
    // Switch drive.
    output logic      [2:0] o_switch_on
);

    lsc_state_t state_q;
    logic [1:0] sel_q;
    logic [9:0] cnt_q;
    logic       change;

    assign change = (i_sel != sel_q);

    // Last select seen.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            sel_q <= 2'h0;
        end else begin
            sel_q <= i_sel;
        end
    end

    // A change opens all switches, waits the overlap delay, then closes the selected one, none for select 0.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q     <= LSC_ST_CLOSED;
            cnt_q       <= 10'h000;
            o_switch_on <= 3'h0;
        end else if (change) begin
            state_q <= LSC_ST_OPEN_WAIT; // R10
            cnt_q   <= 10'(LSC_OPEN_WAIT_CYC);
        end else begin
            case (state_q)
                LSC_ST_OPEN_WAIT: begin
                    if (cnt_q == 10'h000) begin
                        o_switch_on <= 3'h0; // R10
                        state_q     <= LSC_ST_BBM_WAIT;
                        cnt_q       <= lsc_bbm_cycles(i_bbm_code); // R8
                    end else begin
                        cnt_q <= cnt_q - 10'h001;
                    end
                end
                LSC_ST_BBM_WAIT: begin
                    if (cnt_q == 10'h000) begin
                        o_switch_on <= lsc_sel_to_switch(sel_q);
                        state_q     <= LSC_ST_CLOSED;
                    end else begin
                        cnt_q <= cnt_q - 10'h001;
                    end
                end
                default: begin
                    state_q <= LSC_ST_CLOSED;
                end
            endcase
        end
    end

    // Switches open a fixed number of cycles after a settled change.
    a_open_latency: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R10
        change ##1 (!change)[*7] |=> (o_switch_on == 3'h0))
        else $error("switches not open after select change");

    // Switches hold while the open wait counts down.
    a_open_hold: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R10
        (state_q == LSC_ST_OPEN_WAIT) && (cnt_q != 10'h000) && !change |=> $stable(o_switch_on))
        else $error("switches moved during open wait");

endmodule

// >>> lsc_pkg.sv
/*
 * Constants, types and helper functions for the LED switch and current
 * configuration register bank.
 * Assumes an 8-bit register port and one 25 MHz system clock.
 */
// Functional notes
// (R1) Offset 06h is a read/write byte with the low eight bits of the channel two current code.
// (R2) Offset 07h is a read/write byte whose bits 1:0 are bits 9:8 of the channel three current code.
// (R3) Offset 08h is a read/write byte with the low eight bits of the channel three current code.
// (R4) Software keeps each current code at or below the safe limit, which is still to be confirmed.
// (R5) Bits 7, 6 and 5 at offset 09h drive the channel three, two and one switches in direct mode only.
// (R6) Bits 4:0 at offset 09h are the lockout threshold trim, 2.3 V at zero and 4.5 V at all ones.
// (R7) Offset 0Ah holds measure enable, calibration disable, gain select and input select.
// (R8) Offset 0Bh holds the switch overlap delay byte and resets to zero.
// (R9) Every register from 06h to 0Bh reads and writes in full and resets to zero.
// (R10) Switches open 333 to 444 ns after the channel select input changes, before the overlap delay.
// (R11) Software writes zero to the spare upper bits of each current high register.
package lsc_pkg;

    // Register offsets.
    localparam logic [7:0] LSC_OFF_CH2_LOW  = 8'h06;
    localparam logic [7:0] LSC_OFF_CH3_HIGH = 8'h07;
    localparam logic [7:0] LSC_OFF_CH3_LOW  = 8'h08;
    localparam logic [7:0] LSC_OFF_SW_TRIM  = 8'h09;
    localparam logic [7:0] LSC_OFF_MEASURE  = 8'h0A;
    localparam logic [7:0] LSC_OFF_OVERLAP  = 8'h0B;

    // Value of every register after reset.
    localparam logic [7:0] LSC_RST_VAL = 8'h00;

    // Field positions.
    localparam int LSC_BIT_SW_THREE = 7;
    localparam int LSC_BIT_SW_TWO   = 6;
    localparam int LSC_BIT_SW_ONE   = 5;
    localparam int LSC_TRIM_LSB     = 0;
    localparam int LSC_BIT_MEAS_EN  = 7;
    localparam int LSC_BIT_CAL_DIS  = 6;
    localparam int LSC_GAIN_LSB     = 4;
    localparam int LSC_INSEL_LSB    = 0;

    // Timing figures in ns and derived cycle counts.
    localparam int LSC_CLK_NS        = 40;
    localparam int LSC_OPEN_MIN_NS   = 333;
    localparam int LSC_OPEN_MAX_NS   = 444;
    localparam int LSC_OPEN_MIN_CYC  = (LSC_OPEN_MIN_NS + LSC_CLK_NS - 1) / LSC_CLK_NS;
    localparam int LSC_OPEN_MAX_CYC  = LSC_OPEN_MAX_NS / LSC_CLK_NS;
    localparam int LSC_OPEN_LAT_CYC  = 3;
    localparam int LSC_OPEN_WAIT_CYC = LSC_OPEN_MIN_CYC - LSC_OPEN_LAT_CYC;
    localparam int LSC_BBM_BASE_NS   = 333;
    localparam int LSC_BBM_STEP_NS   = 111;

    // Switch sequencer states.
    typedef enum logic [1:0] {
        LSC_ST_CLOSED,
        LSC_ST_OPEN_WAIT,
        LSC_ST_BBM_WAIT
    } lsc_state_t;

    // Overlap delay code to whole cycles, rounded up.
    function automatic logic [9:0] lsc_bbm_cycles(input logic [7:0] code);
        int ns;
        ns = LSC_BBM_BASE_NS + (int'(code) - 1) * LSC_BBM_STEP_NS;
        if (code == 8'h00) begin
            return 10'h000;
        end
        return 10'((ns + LSC_CLK_NS - 1) / LSC_CLK_NS);
    endfunction

    // Channel select to one-hot switch set, bit 0 for channel one.
    function automatic logic [2:0] lsc_sel_to_switch(input logic [1:0] sel);
        case (sel)
            2'h1:    return 3'h1;
            2'h2:    return 3'h2;
            2'h3:    return 3'h4;
            default: return 3'h0;
        endcase
    endfunction

    // True for an offset that holds a register of this bank.
    function automatic logic lsc_is_mapped(input logic [7:0] addr);
        return (addr >= LSC_OFF_CH2_LOW) && (addr <= LSC_OFF_OVERLAP);
    endfunction

endpackage

// >>> lsc_regs.sv
/*
 * LED switch and current configuration register bank with the
 * break-before-make switch sequencing it steers.
 * Assumes a single-cycle register port on the system clock, a direct
 * mode enable and channel two high bits from elsewhere on that clock,
 * and a channel select pin from outside the clock domain.
 */
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module lsc_regs
    import lsc_pkg::*;
(
    // Clock and reset.
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    // Register port.
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // Inputs from the rest of the device.
    input  wire logic       i_direct_mode_en,
    input  wire logic [1:0] i_channel_two_current_high,
    // Channel select pin.
    input  wire logic [1:0] i_channel_select_input,
    // Current codes.
    output logic      [9:0] o_channel_two_current_code,
    output logic      [9:0] o_channel_three_current_code,
    // Switch drive.
    output logic            o_channel_one_switch,
    output logic            o_channel_two_switch,
    output logic            o_channel_three_switch,
    // Lockout trim.
    output logic      [4:0] o_lockout_threshold_trim,
    // Measurement multiplexer.
    output logic            o_measure_mux_enable,
    output logic            o_measure_calibration_disable,
    output logic      [1:0] o_measure_gain_select,
    output logic      [3:0] o_measure_input_select,
    // Overlap delay.
    output logic      [7:0] o_switch_overlap_delay
);

    logic [7:0] ch2_low_q;
    logic [7:0] ch3_high_q;
    logic [7:0] ch3_low_q;
    logic [7:0] sw_trim_q;
    logic [7:0] measure_q;
    logic [7:0] overlap_q;
    logic [7:0] rdata_d;
    logic [1:0] sel_sync;
    logic [2:0] seq_switch;
    logic [2:0] direct_switch;
    logic [2:0] switch_q;

    // Write strobes per register.
    logic wr_ch2_low;
    logic wr_ch3_high;
    logic wr_ch3_low;
    logic wr_sw_trim;
    logic wr_measure;
    logic wr_overlap;

    // Address decode of the write strobe.
    assign wr_ch2_low  = i_wr && (i_addr == LSC_OFF_CH2_LOW);
    assign wr_ch3_high = i_wr && (i_addr == LSC_OFF_CH3_HIGH);
    assign wr_ch3_low  = i_wr && (i_addr == LSC_OFF_CH3_LOW);
    assign wr_sw_trim  = i_wr && (i_addr == LSC_OFF_SW_TRIM);
    assign wr_measure  = i_wr && (i_addr == LSC_OFF_MEASURE);
    assign wr_overlap  = i_wr && (i_addr == LSC_OFF_OVERLAP);

    // Channel two current low byte.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            ch2_low_q <= LSC_RST_VAL; // R9
        end else if (wr_ch2_low) begin
            ch2_low_q <= i_wdata; // R1
        end
    end

    // Channel three current high byte; spare bits are stored as written.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            ch3_high_q <= LSC_RST_VAL; // R9
        end else if (wr_ch3_high) begin
            ch3_high_q <= i_wdata; // R2
        end
    end

    // Channel three current low byte.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            ch3_low_q <= LSC_RST_VAL; // R9
        end else if (wr_ch3_low) begin
            ch3_low_q <= i_wdata; // R3
        end
    end

    // Direct switch bits and lockout trim.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            sw_trim_q <= LSC_RST_VAL; // R9
        end else if (wr_sw_trim) begin
            sw_trim_q <= i_wdata; // R5
        end
    end

    // Measurement multiplexer control.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            measure_q <= LSC_RST_VAL; // R9
        end else if (wr_measure) begin
            measure_q <= i_wdata; // R7
        end
    end

    // Switch overlap delay.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            overlap_q <= LSC_RST_VAL; // R8
        end else if (wr_overlap) begin
            overlap_q <= i_wdata; // R8
        end
    end

    // Read multiplexer; unmapped offsets read as zero.
    always_comb begin
        case (i_addr)
            LSC_OFF_CH2_LOW:  rdata_d = ch2_low_q; // R9
            LSC_OFF_CH3_HIGH: rdata_d = ch3_high_q;
            LSC_OFF_CH3_LOW:  rdata_d = ch3_low_q;
            LSC_OFF_SW_TRIM:  rdata_d = sw_trim_q;
            LSC_OFF_MEASURE:  rdata_d = measure_q;
            LSC_OFF_OVERLAP:  rdata_d = overlap_q;
            default:          rdata_d = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= rdata_d;
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // Full current codes from high and low bytes.
    assign o_channel_two_current_code   = {i_channel_two_current_high, ch2_low_q}; // R1
    assign o_channel_three_current_code = {ch3_high_q[1:0], ch3_low_q}; // R2 R3

    // Field outputs.
    assign o_lockout_threshold_trim      = sw_trim_q[LSC_TRIM_LSB +: 5]; // R6
    assign o_measure_mux_enable          = measure_q[LSC_BIT_MEAS_EN]; // R7
    assign o_measure_calibration_disable = measure_q[LSC_BIT_CAL_DIS];
    assign o_measure_gain_select         = measure_q[LSC_GAIN_LSB +: 2];
    assign o_measure_input_select        = measure_q[LSC_INSEL_LSB +: 4];
    assign o_switch_overlap_delay        = overlap_q; // R8

    // Bring the select pin into the clock domain.
    lsc_sync #(
        .WIDTH (2)
    ) u_sel_sync (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_async   (i_channel_select_input),
        .o_sync    (sel_sync)
    );

    // Sequence the switches from the select pin.
    lsc_bbm_seq u_seq (
        .i_clk_sys   (i_clk_sys),
        .i_resetn    (i_resetn),
        .i_sel       (sel_sync),
        .i_bbm_code  (overlap_q),
        .o_switch_on (seq_switch)
    );

    // Direct mode switch bits, channel one in bit 0.
    assign direct_switch = {sw_trim_q[LSC_BIT_SW_THREE],
                            sw_trim_q[LSC_BIT_SW_TWO],
                            sw_trim_q[LSC_BIT_SW_ONE]};

    // Direct mode overrides the sequencer.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            switch_q <= 3'h0;
        end else if (i_direct_mode_en) begin
            switch_q <= direct_switch; // R5
        end else begin
            switch_q <= seq_switch; // R10
        end
    end

    assign o_channel_one_switch   = switch_q[0];
    assign o_channel_two_switch   = switch_q[1];
    assign o_channel_three_switch = switch_q[2];

    // Checks on the register port.
    a_read_back: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        i_wr && lsc_is_mapped(i_addr) ##1 i_rd && (i_addr == $past(i_addr))
        |=> (o_rdata == $past(i_wdata, 2))) // R9
        else $error("register read back differs from write");

    a_unmapped_zero: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        i_rd && !lsc_is_mapped(i_addr) |=> (o_rdata == 8'h00)) // R9
        else $error("unmapped read not zero");

    a_rdata_idle: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        !i_rd |=> (o_rdata == 8'h00)) // R9
        else $error("read data outside read cycle");

    // Checks on the current codes.
    a_ch2_low: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        wr_ch2_low |=> (o_channel_two_current_code[7:0] == $past(i_wdata))) // R1
        else $error("channel two low byte not applied");

    a_ch3_high: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        wr_ch3_high |=> (o_channel_three_current_code[9:8] == $past(i_wdata[1:0]))) // R2
        else $error("channel three high bits not applied");

    a_ch3_low: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        wr_ch3_low ##1 !wr_ch3_low |=> (o_channel_three_current_code[7:0] == $past(i_wdata, 2))) // R3
        else $error("channel three low byte not held");

    // Checks on trim, multiplexer and delay fields.
    a_trim_field: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        wr_sw_trim |=> (o_lockout_threshold_trim == $past(i_wdata[4:0]))) // R6
        else $error("lockout trim not applied");

    a_measure_field: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        wr_measure |=> ({o_measure_mux_enable, o_measure_calibration_disable,
                         o_measure_gain_select, o_measure_input_select} == $past(i_wdata))) // R7
        else $error("measure controls not applied");

    a_overlap_field: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        wr_overlap |=> (o_switch_overlap_delay == $past(i_wdata))) // R8
        else $error("overlap delay not applied");

    // Checks on direct mode and on the sequencer path.
    a_direct_switch: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        i_direct_mode_en |=> ({o_channel_three_switch, o_channel_two_switch,
                               o_channel_one_switch} == $past(direct_switch))) // R5
        else $error("direct switch bits not followed");

    a_seq_switch: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        !i_direct_mode_en |=> (switch_q == $past(seq_switch))) // R10
        else $error("sequencer switch state not followed");

    // All six registers side by side, so the checks below watch the whole bank.
    logic [47:0] bank_all;
    assign bank_all = {ch2_low_q, ch3_high_q, ch3_low_q, sw_trim_q, measure_q, overlap_q};

    // Reset clears the bank; the first edge after release still sees zero.
    a_reset_clear: assert property (@(posedge i_clk_sys) // R9
        $rose(i_resetn) |-> (bank_all == 48'h0))
        else $error("bank not cleared by reset");

    // Without a write strobe every register keeps its value.
    a_hold_state: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R9
        !i_wr |=> $stable(bank_all))
        else $error("register changed without a write");

    // Writes outside the bank leave every register alone.
    a_unmapped_write: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R9
        i_wr && !lsc_is_mapped(i_addr) |=> $stable(bank_all))
        else $error("unmapped write changed a register");

    // Channel two high bits pass straight through from the neighbouring register.
    a_ch2_high: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // R1
        o_channel_two_current_code[9:8] == i_channel_two_current_high)
        else $error("channel two high bits not passed through");

    // Main scenarios.
    c_write_read: cover property (@(posedge i_clk_sys) disable iff (!i_resetn)
        wr_overlap ##1 (i_rd && (i_addr == LSC_OFF_OVERLAP)));

    c_direct_on: cover property (@(posedge i_clk_sys) disable iff (!i_resetn)
        i_direct_mode_en ##1 o_channel_three_switch);

    c_seq_close: cover property (@(posedge i_clk_sys) disable iff (!i_resetn)
        !i_direct_mode_en ##1 $rose(o_channel_two_switch));

    c_unmapped: cover property (@(posedge i_clk_sys) disable iff (!i_resetn)
        i_rd && !lsc_is_mapped(i_addr));

endmodule

// >>> lsc_regs_tb.sv
/*
 * Self-checking testbench for the LED switch and current configuration register bank.
 * Assumes the bank as top, driven directly with no partner model, on a 25 MHz clock.
 */
`timescale 1ns/1ps
module lsc_regs_tb
    import lsc_pkg::*;
();
    // Design inputs.
    logic       i_clk_sys;
    logic       i_resetn;
    logic [7:0] i_addr;
    logic [7:0] i_wdata;
    logic       i_wr;
    logic       i_rd;
    logic       i_direct_mode_en;
    logic [1:0] i_channel_two_current_high;
    logic [1:0] i_channel_select_input;
    // Design outputs.
    logic [7:0] o_rdata;
    logic [9:0] o_channel_two_current_code;
    logic [9:0] o_channel_three_current_code;
    logic       o_channel_one_switch;
    logic       o_channel_two_switch;
    logic       o_channel_three_switch;
    logic [4:0] o_lockout_threshold_trim;
    logic       o_measure_mux_enable;
    logic       o_measure_calibration_disable;
    logic [1:0] o_measure_gain_select;
    logic [3:0] o_measure_input_select;
    logic [7:0] o_switch_overlap_delay;
    // Bench state.
    int         n_errors;
    int         compares;
    int         cycles;
    int         seed;
    logic [7:0] mdl [6:11];
    logic [2:0] sw;

    assign sw = {o_channel_three_switch, o_channel_two_switch, o_channel_one_switch};

    lsc_regs u_lsc_regs (
        .i_clk_sys                     (i_clk_sys),
        .i_resetn                      (i_resetn),
        .i_addr                        (i_addr),
        .i_wdata                       (i_wdata),
        .i_wr                          (i_wr),
        .i_rd                          (i_rd),
        .o_rdata                       (o_rdata),
        .i_direct_mode_en              (i_direct_mode_en),
        .i_channel_two_current_high    (i_channel_two_current_high),
        .i_channel_select_input        (i_channel_select_input),
        .o_channel_two_current_code    (o_channel_two_current_code),
        .o_channel_three_current_code  (o_channel_three_current_code),
        .o_channel_one_switch          (o_channel_one_switch),
        .o_channel_two_switch          (o_channel_two_switch),
        .o_channel_three_switch        (o_channel_three_switch),
        .o_lockout_threshold_trim      (o_lockout_threshold_trim),
        .o_measure_mux_enable          (o_measure_mux_enable),
        .o_measure_calibration_disable (o_measure_calibration_disable),
        .o_measure_gain_select         (o_measure_gain_select),
        .o_measure_input_select        (o_measure_input_select),
        .o_switch_overlap_delay        (o_switch_overlap_delay)
    );

    // Free-running 40 ns clock.
    initial begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end

    // Cuts a hung run short well after the expected length.
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("timeout after %0d cycles", cycles);
            tally_and_finish();
        end
    end

    // Counts one comparison and reports a mismatch at once.
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("compares %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Offsets 06h to 0Bh hold registers, nothing else does.
    function automatic logic mapped(input logic [7:0] a);
        return (a >= 8'h06) && (a <= 8'h0B);
    endfunction

    // Break-before-make gap in ns for an overlap code.
    function automatic int bbm_ns(input logic [7:0] code);
        return (code == 8'h00) ? 0 : 333 + (int'(code) - 1) * 111;
    endfunction

    // One-cycle write strobe; the model follows mapped offsets only.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr    <= 1'b0;
        if (mapped(a)) begin
            mdl[a] = d;
        end
    endtask

    // One-cycle read strobe; right behind a write strobe it follows with no gap.
    // Data stand only in the following cycle.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        if (!i_wr) begin
            @(posedge i_clk_sys);
        end
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd   <= 1'b0;
        #1 check(16'(o_rdata), 16'(exp));
        @(posedge i_clk_sys);
        #1 check(16'(o_rdata), 16'h0000);
    endtask

    // Compares every configuration output with the register model.
    task automatic check_outputs();
        check(16'(o_channel_two_current_code), 16'({i_channel_two_current_high, mdl[6]}));
        check(16'(o_channel_three_current_code), 16'({mdl[7][1:0], mdl[8]}));
        check(16'(o_lockout_threshold_trim), 16'(mdl[9][4:0]));
        check(16'({o_measure_mux_enable, o_measure_calibration_disable, o_measure_gain_select,
                   o_measure_input_select}), 16'(mdl[10]));
        check(16'(o_switch_overlap_delay), 16'(mdl[11]));
    endtask

    // Reads every register back against the model.
    task automatic read_all();
        for (int a = 6; a <= 11; a++) begin
            rd(8'(a), mdl[a]);
        end
    endtask

    // Resets the bank for two cycles and clears the model.
    task automatic do_reset();
        @(posedge i_clk_sys);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        for (int a = 6; a <= 11; a++) begin
            mdl[a] = 8'h00;
        end
    endtask

    // Moves the select pin and times the opening and the overlap gap.
    task automatic select(input logic [1:0] s, input logic [7:0] code);
        int n;
        int m;
        wr(8'h0B, code);
        @(posedge i_clk_sys);
        i_channel_select_input <= s;
        n = 0;
        do begin
            @(posedge i_clk_sys);
            #1 n++;
        end while (sw !== 3'h0 && n < 50);
        check(16'((n * 40 >= LSC_OPEN_MIN_NS) && (n * 40 <= LSC_OPEN_MAX_NS)), 16'h0001);
        m = 0;
        do begin
            @(posedge i_clk_sys);
            #1 m++;
        end while (sw === 3'h0 && m < 800);
        check(16'((m * 40 >= bbm_ns(code)) && (m * 40 <= bbm_ns(code) + 160)), 16'h0001);
        check(16'(sw), 16'(3'h1 << (s - 2'h1)));
        $display("select %0d with overlap code %h done", s, code);
    endtask

    // Main sequence.
    initial begin
        logic [7:0] a;
        logic [7:0] d;
        seed = 63157;
        n_errors = 0;
        compares = 0;
        cycles = 0;
        i_resetn = 1'b0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_direct_mode_en = 1'b0;
        i_channel_two_current_high = 2'h0;
        i_channel_select_input = 2'h0;
        for (int k = 6; k <= 11; k++) begin
            mdl[k] = 8'h00;
        end
        repeat (2) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        #1 check_outputs();
        read_all();
        $display("test reset values done");

        // Boundary patterns, then random traffic with the select pin idle.
        for (int k = 6; k <= 11; k++) begin
            d = (k == 7) ? 8'h03 : 8'hFF;
            wr(8'(k), d);
            rd(8'(k), d);
            wr(8'(k), 8'h00);
        end
        for (int k = 0; k < 60; k++) begin
            a = 8'h06 + 8'($unsigned($random(seed)) % 6);
            d = 8'($random(seed));
            if (a == 8'h07) begin
                d = d & 8'h02;
            end
            @(posedge i_clk_sys);
            i_channel_two_current_high <= 2'($random(seed)) & 2'h2;
            wr(a, d);
            @(posedge i_clk_sys);
            #1 check_outputs();
            check(16'(sw), 16'h0000);
            if (k % 5 == 0) begin
                rd(a, mdl[a]);
            end
        end
        $display("test random access done");

        // Unmapped offsets read as zero and leave the bank alone.
        wr(8'h05, 8'hAA);
        wr(8'h0C, 8'h55);
        wr(8'hFF, 8'h3C);
        rd(8'h05, 8'h00);
        rd(8'h0C, 8'h00);
        read_all();
        $display("test unmapped offsets done");

        // Direct mode drives the switches from offset 09h.
        @(posedge i_clk_sys);
        i_direct_mode_en <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            wr(8'h09, {3'(k), 5'h0A});
            repeat (2) @(posedge i_clk_sys);
            #1 check(16'(sw), 16'(k));
        end
        wr(8'h09, 8'h00);
        @(posedge i_clk_sys);
        i_direct_mode_en <= 1'b0;
        $display("test direct mode done");

        // Select sequencing across overlap codes, including the largest.
        wr(8'h0B, 8'h00);
        @(posedge i_clk_sys);
        i_channel_select_input <= 2'h1;
        repeat (30) @(posedge i_clk_sys);
        #1 check(16'(sw), 16'h0001);
        select(2'h2, 8'h00);
        select(2'h3, 8'h01);
        select(2'h1, 8'h02);
        select(2'h2, 8'($random(seed)) & 8'h3F);
        select(2'h3, 8'hFF);
        @(posedge i_clk_sys);
        i_channel_select_input <= 2'h0;
        repeat (30) @(posedge i_clk_sys);
        #1 check(16'(sw), 16'h0000);
        $display("test select sequencing done");

        // A second reset in mid-run clears every register.
        do_reset();
        #1 check_outputs();
        read_all();
        $display("test second reset done");
        tally_and_finish();
    end
endmodule

// >>> lsc_sync.sv
/*
 * Two flip-flop synchroniser for a bus of levels.
 * Assumes the input changes slowly against the clock.
 */
`timescale 1ns/1ps
module lsc_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset.
    input  wire logic             i_clk_sys,
    input  wire logic             i_resetn,
    // Data.
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule
